// ### hw/cbm_balance_ctrl.sv
// Overview of operation
// - Mode 1xx is automatic, 01x manual, 001 emergency discharge.
// - Writing the mode starts balancing; mode persists until rewritten, exits leave it unchanged.
// - Alive counter, unit clear only on mode change or disable; state, timer on any mode write.
// - Alive counter advances once per second while balancing runs.
// - A hardware health check runs before switching; failure sets its flag.
// - Timer expiry, thermal fault or undervoltage end balancing; mode stays.
// - Blocked writes after start are discarded and set the write reject flag.
// - Auto modes reject restart, mask, all expiries, UV threshold, delay control.
// - Manual rejects only expiry one; emergency rejects expiry one and delay control.
// - Restart refreshes the watchdog only in manual balancing; otherwise no action.
// - With use-minimum-cell set, UV threshold writes are rejected during scans.
// - Any non-disable mode write zeroes the timer and relaunches the mode.
// - Manual switch on when enabled, timer within expiry one, not suspended.
// - Manual timer advances in real time regardless of enables or suspension.
// - Manual expiry one of all ones disables the watchdog timeout.
// - Manual mode ignores the UV exit threshold; measurements run concurrently.
// - Restart after manual expiry does nothing; host must rewrite the mode.
// - Suspend option turns switches off during measurement, manual modes only.
// - Settling delay 0 to 24.48 ms in 96 us steps from acquisition enable.
// - Cell delay is upper byte, diagnostic lower; mux select under suspend picks which.
// - Settle delay writes rejected during measurement or auto balancing.
// - ADC and comparator aux summaries are ORed into status-one bits.
// - Auto individual drives even and odd switches in alternate phases.
// - Normal auto completion gives state 10; faults stop switching with 11.
// - Expiry fields are ten bits; unit follows the selected mode.
`timescale 1ns/1ns
module cbm_balance_ctrl
	import cbm_pkg::*;
#(
	parameter int NUM_CELLS = 14,
	parameter int VOLT_W    = 14,
	parameter int SEC_CYC   = SEC_CYCLES
) (
	input  wire logic                              core_clk,
	input  wire logic                              rst_b,
	input  wire logic                              mode_wr,
	input  wire logic [2:0]                        mode_wdata,
	input  wire logic                              swctrl_wr,
	input  wire logic                              restart_wdata,
	input  wire logic [NUM_CELLS-1:0]              mask_wdata,
	input  wire logic                              exp_wr,
	input  wire logic [3:0]                        exp_idx,
	input  wire logic [9:0]                        exp_wdata,
	input  wire logic                              uvthr_wr,
	input  wire logic [VOLT_W-1:0]                 uvthr_wdata,
	input  wire logic                              min_cell_wdata,
	input  wire logic                              dlyctrl_wr,
	input  wire logic [7:0]                        dlyctrl_wdata,
	input  wire logic                              settle_wr,
	input  wire logic [15:0]                       settle_wdata,
	input  wire logic [1:0]                        measure_exit_enable,
	input  wire logic                              measure_suspend_switches,
	input  wire logic                              alternate_mux_select,
	input  wire logic                              meas_in_progress,
	input  wire logic                              scan_in_progress,
	input  wire logic                              acq_enable,
	input  wire logic                              thermal_fault,
	input  wire logic                              hw_check_fail,
	input  wire logic [NUM_CELLS-1:0][VOLT_W-1:0]  cell_voltage,
	input  wire logic                              adc_aux_ov,
	input  wire logic                              comp_aux_ov,
	input  wire logic                              adc_aux_uv,
	input  wire logic                              comp_aux_uv,
	input  wire logic                              reject_clr,
	input  wire logic                              health_clr,
	output logic [NUM_CELLS-1:0]                   balance_switch,
	output logic [2:0]                             balance_mode_select,
	output logic                                   even_phase,
	output logic                                   odd_phase,
	output logic [7:0]                             delay_control,
	output logic                                   settle_done,
	output cbm_status_t                            status,
	output cbm_status_one_t                        status_word_one,
	output cbm_status_two_t                        status_word_two
);

	localparam int STEP_W = $clog2(SETTLE_STEP_CYCLES);

	if (NUM_CELLS < 2 || NUM_CELLS > 15 || VOLT_W < 1) begin : g_chk
		$error("cbm_balance_ctrl: NUM_CELLS must be 2..15 and VOLT_W positive");
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decode

	function automatic logic is_auto(input logic [2:0] m);
		return m[2];
	endfunction

	function automatic logic is_manual(input logic [2:0] m);
		return m[2:1] == 2'b01;
	endfunction

	function automatic logic is_emerg(input logic [2:0] m);
		return m == MODE_EMERG;
	endfunction

	function automatic logic [1:0] unit_of(input logic [2:0] m);
		if (m == MODE_OFF)
			return UNIT_NONE;
		else if (m == MODE_EMERG)
			return UNIT_HOUR;
		else
			return m[0] ? UNIT_MIN : UNIT_SEC;
	endfunction

	cbm_state_t                         st;
	logic [2:0]                         mode;
	logic [9:0]                         timer;
	logic [1:0]                         alive;
	logic [1:0]                         unit;
	logic [NUM_CELLS-1:0]               mask;
	logic [9:0]                         exp_q [NUM_CELLS];
	logic [VOLT_W-1:0]                  uv_exit_threshold;
	logic                               use_min_cell_threshold;
	logic [7:0]                         cell_settle_delay;
	logic [7:0]                         diag_settle_delay;
	logic                               reject_flag;
	logic                               health_flag;
	logic                               phase;
	logic                               sec_tick;
	logic                               min_tick;
	logic                               hour_tick;
	logic                               unit_tick;
	logic                               restart_ok;
	logic                               mode_change;
	logic                               rej_sw;
	logic                               rej_exp;
	logic                               rej_uv;
	logic                               rej_dly;
	logic                               rej_settle;
	logic                               exit_done;
	logic [NUM_CELLS-1:0]               next_switch;
	logic [STEP_W-1:0]                  step_cnt;
	logic [7:0]                         steps_left;
	logic                               settle_busy;

	cbm_tick_gen #(
		.SEC_CYC (SEC_CYC)
	) u_tick (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.restart   (mode_wr),
		.sec_tick  (sec_tick),
		.min_tick  (min_tick),
		.hour_tick (hour_tick)
	);

	always_comb begin
		unique case (unit)
			UNIT_SEC:  unit_tick = sec_tick;
			UNIT_MIN:  unit_tick = min_tick;
			UNIT_HOUR: unit_tick = hour_tick;
			UNIT_NONE: unit_tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Write acceptance

	// blocked while an auto mode is selected
	// expiry one blocked in all modes but disable; delay control also in emergency
	// threshold taken from a scan in flight
	// settle delay frozen during measurement or auto
	assign rej_sw     = swctrl_wr && is_auto(mode);
	assign rej_exp    = exp_wr && mode != MODE_OFF && (exp_idx == 4'h1 || is_auto(mode));
	assign rej_uv     = uvthr_wr && (is_auto(mode) || (use_min_cell_threshold && scan_in_progress));
	assign rej_dly    = dlyctrl_wr && (is_auto(mode) || is_emerg(mode));
	assign rej_settle = settle_wr && (meas_in_progress || is_auto(mode));

	// Setting wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			reject_flag <= 1'b0;
		else if (rej_sw || rej_exp || rej_uv || rej_dly || rej_settle)
			reject_flag <= 1'b1;
		else if (reject_clr)
			reject_flag <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mask                   <= '0;
			uv_exit_threshold      <= '0;
			use_min_cell_threshold <= 1'b0;
			delay_control          <= DLY_RESET;
			cell_settle_delay      <= SETTLE_RESET;
			diag_settle_delay      <= SETTLE_RESET;
		end else begin
			if (swctrl_wr && !rej_sw)
				mask <= mask_wdata;
			if (uvthr_wr && !rej_uv) begin
				uv_exit_threshold      <= uvthr_wdata;
				use_min_cell_threshold <= min_cell_wdata;
			end
			if (dlyctrl_wr && !rej_dly)
				delay_control <= dlyctrl_wdata;
			// upper byte cell, lower byte diagnostic
			if (settle_wr && !rej_settle) begin
				cell_settle_delay <= settle_wdata[15:8];
				diag_settle_delay <= settle_wdata[7:0];
			end
		end
	end

	// Expiry index is one-based; out-of-range indexes are dropped, silently except in auto modes, where every expiry write is flagged
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NUM_CELLS; i++) begin
			if (!rst_b)
				exp_q[i] <= EXP_RESET;
			else if (exp_wr && !rej_exp && exp_idx == 4'(i + 1))
				exp_q[i] <= exp_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	// mode write starts; never changed by an exit
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			mode <= MODE_OFF;
		else if (mode_wr)
			mode <= mode_wdata;
	end

	// all-ones expiry one never times out in manual
	always_comb begin
		logic tmr_all;
		logic uv_all;
		tmr_all = 1'b1;
		uv_all  = measure_exit_enable == UV_EXIT_ALL;
		for (int i = 0; i < NUM_CELLS; i++) begin
			if (mask[i] && timer <= exp_q[i])
				tmr_all = 1'b0;
			if (mask[i] && cell_voltage[i] >= uv_exit_threshold)
				uv_all = 1'b0;
		end
		if (is_manual(mode))
			exit_done = exp_q[0] != EXP_DISABLE && timer > exp_q[0];
		else if (is_emerg(mode))
			exit_done = timer > exp_q[0];
		else if (mode[1])
			exit_done = timer > exp_q[0] || uv_all;
		else
			exit_done = tmr_all || uv_all;
	end

	// any non-disable write relaunches through the health check
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			st <= ST_OFF;
		else if (mode_wr)
			st <= (mode_wdata == MODE_OFF) ? ST_OFF : ST_CHECK;
		else begin
			unique case (st)
				ST_OFF, ST_DONE, ST_FAULT: st <= st;
				ST_CHECK: st <= hw_check_fail ? ST_FAULT : ST_RUN;
				ST_RUN: begin
					if (thermal_fault)
						st <= ST_FAULT;
					else if (exit_done)
						st <= ST_DONE;
				end
			endcase
		end
	end

	// sticky failure flag, set wins over clear
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			health_flag <= 1'b0;
		else if (st == ST_CHECK && hw_check_fail && !mode_wr)
			health_flag <= 1'b1;
		else if (health_clr)
			health_flag <= 1'b0;
	end

	// restart acts only in manual run
	// once expired the run state is left, so restart is void
	assign restart_ok  = swctrl_wr && restart_wdata && is_manual(mode) && st == ST_RUN;
	assign mode_change = mode_wr && (mode_wdata != mode || mode_wdata == MODE_OFF);

	// one step per unit while running, whatever the switches do
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			timer <= '0;
		else if (mode_wr || restart_ok)
			timer <= '0;
		else if (st == ST_RUN && unit_tick && timer != EXP_DISABLE)
			timer <= timer + 10'h001;
	end

	// alive counter and unit survive a same-mode rewrite
	// 1 Hz alive count with roll-over
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			alive <= '0;
			unit  <= UNIT_NONE;
		end else if (mode_change) begin
			alive <= '0;
			unit  <= unit_of(mode_wdata);
		end else if (st == ST_RUN && sec_tick) begin
			alive <= alive + 2'h1;
		end
	end

	// Phase flips each second; both halves change on one edge, never overlap
	always_ff @(posedge core_clk) begin
		if (!rst_b || mode_wr)
			phase <= 1'b0;
		else if (st == ST_RUN && sec_tick)
			phase <= ~phase;
	end

	////////////////////////////////////////////////////////////////////////
	// Switch drive

	always_comb begin
		logic [9:0] lim;
		logic       ph_ok;
		logic       uv_ok;
		lim         = '0;
		ph_ok       = 1'b0;
		uv_ok       = 1'b0;
		next_switch = '0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			lim   = mode[1] ? exp_q[0] : exp_q[i];
			// Index 0 is cell 1, an odd cell
			ph_ok = (i % 2 == 1) ? ~phase : phase;
			uv_ok = measure_exit_enable != UV_EXIT_ALL || cell_voltage[i] >= uv_exit_threshold;
			if (is_manual(mode))
				next_switch[i] = mask[i] && (timer <= exp_q[0] || exp_q[0] == EXP_DISABLE)
					&& !(measure_suspend_switches && meas_in_progress);
			else if (is_emerg(mode))
				next_switch[i] = timer <= exp_q[0] && ph_ok;
			else
				next_switch[i] = mask[i] && timer <= lim && ph_ok && uv_ok;
		end
		if (st != ST_RUN || thermal_fault || mode_wr || exit_done)
			next_switch = '0;
	end

	// switches registered on the core clock
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			balance_switch <= '0;
		else
			balance_switch <= next_switch;
	end

	////////////////////////////////////////////////////////////////////////
	// Settling delay

	// whole 96 us steps counted from acquisition enable
	// mux select picks diagnostic delay under suspension
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			settle_busy <= 1'b0;
			settle_done <= 1'b0;
			step_cnt    <= '0;
			steps_left  <= '0;
		end else begin
			settle_done <= 1'b0;
			if (acq_enable) begin
				settle_busy <= 1'b1;
				step_cnt    <= '0;
				steps_left  <= (measure_suspend_switches && alternate_mux_select) ?
					diag_settle_delay : cell_settle_delay;
			end else if (settle_busy) begin
				if (steps_left == 8'h00) begin
					settle_busy <= 1'b0;
					settle_done <= 1'b1;
				end else if (step_cnt == STEP_W'(SETTLE_STEP_CYCLES - 1)) begin
					step_cnt   <= '0;
					steps_left <= steps_left - 8'h01;
				end else begin
					step_cnt <= step_cnt + STEP_W'(1);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status

	// summary bits for alert path and check byte
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			status_word_one <= '0;
		else begin
			status_word_one.aux_over_summary  <= adc_aux_ov || comp_aux_ov;
			status_word_one.aux_under_summary <= adc_aux_uv || comp_aux_uv;
		end
	end

	always_comb begin
		unique case (st)
			ST_OFF:           status.balance_state = BST_IDLE;
			ST_CHECK, ST_RUN: status.balance_state = BST_RUN;
			ST_DONE:          status.balance_state = BST_DONE;
			ST_FAULT:         status.balance_state = BST_FAULT;
		endcase
		status.balance_elapsed_timer = timer;
		status.alive_counter         = alive;
		status.timer_unit_indicator  = unit;
	end

	assign status_word_two.write_reject_flag      = reject_flag;
	assign status_word_two.health_check_fail_flag = health_flag;
	assign balance_mode_select                    = mode;
	assign even_phase = (st == ST_RUN) && !is_manual(mode) && !phase;
	assign odd_phase  = (st == ST_RUN) && !is_manual(mode) && phase;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_auto_sw_reject: assert property (
		swctrl_wr && is_auto(mode) |=> status_word_two.write_reject_flag && mask == $past(mask))
		else $error("auto mode accepted a switch control write");

	a_exp_one_block: assert property (
		exp_wr && exp_idx == 4'h1 && mode != MODE_OFF |=> exp_q[0] == $past(exp_q[0]) && reject_flag)
		else $error("expiry one changed while balancing");

	a_mode_relaunch: assert property (
		mode_wr && mode_wdata != MODE_OFF |=> timer == 10'h000 && st == ST_CHECK)
		else $error("mode write did not relaunch");

	a_suspend_off: assert property (
		st == ST_RUN && is_manual(mode) && measure_suspend_switches && meas_in_progress
		|=> balance_switch == '0)
		else $error("switch on during suspended measurement");

	a_health_fault: assert property (
		st == ST_CHECK && hw_check_fail && !mode_wr |=> health_flag && status.balance_state == BST_FAULT)
		else $error("failed health check not reported");

	a_thermal_stop: assert property (
		st == ST_RUN && thermal_fault && !mode_wr |=> st == ST_FAULT && balance_switch == '0 [*2])
		else $error("thermal fault did not stop switching");

	a_manual_tick: assert property (
		st == ST_RUN && is_manual(mode) && unit_tick && timer != EXP_DISABLE && !mode_wr && !restart_ok
		|=> timer == $past(timer) + 10'h001)
		else $error("manual timer missed a unit");

	a_settle_reject: assert property (
		settle_wr && meas_in_progress |=> reject_flag && $stable(cell_settle_delay))
		else $error("settle delay write accepted during measurement");

	a_aux_summary: assert property (
		(adc_aux_ov || comp_aux_ov) |=> status_word_one.aux_over_summary)
		else $error("aux over summary missing");

	a_auto_phase: assert property (
		is_auto(mode) || is_emerg(mode) |=> (balance_switch & (balance_switch >> 1)) == '0)
		else $error("adjacent switches on in phased mode");

	a_restart_void: assert property (
		st == ST_DONE && swctrl_wr && restart_wdata && !mode_wr |=> st == ST_DONE && $stable(timer))
		else $error("restart after expiry had an effect");

	c_manual_done: cover property (st == ST_RUN && is_manual(mode) ##1 st == ST_DONE);
	c_auto_done:   cover property (st == ST_RUN && is_auto(mode) ##1 st == ST_DONE);
	c_fault:       cover property (st == ST_RUN ##1 st == ST_FAULT);
	c_reject:      cover property (rej_exp || rej_settle);

endmodule

// ### hw/cbm_pkg.sv
package cbm_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS      = 40;
	localparam int SEC_NS             = 1_000_000_000;
	localparam int SEC_CYCLES         = SEC_NS / CLK_PERIOD_NS;
	localparam int UNITS_PER_NEXT     = 60;
	localparam int SETTLE_STEP_NS     = 96_000;
	localparam int SETTLE_STEP_CYCLES = (SETTLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Balancing mode field encodings
	localparam logic [2:0] MODE_OFF     = 3'h0;
	localparam logic [2:0] MODE_EMERG   = 3'h1;
	localparam logic [2:0] MODE_MAN_SEC = 3'h2;
	localparam logic [2:0] MODE_MAN_MIN = 3'h3;
	localparam logic [2:0] MODE_AI_SEC  = 3'h4;
	localparam logic [2:0] MODE_AI_MIN  = 3'h5;
	localparam logic [2:0] MODE_AG_SEC  = 3'h6;
	localparam logic [2:0] MODE_AG_MIN  = 3'h7;

	// Balance state codes
	localparam logic [1:0] BST_IDLE  = 2'h0;
	localparam logic [1:0] BST_RUN   = 2'h1;
	localparam logic [1:0] BST_DONE  = 2'h2;
	localparam logic [1:0] BST_FAULT = 2'h3;

	// Timer unit codes
	localparam logic [1:0] UNIT_NONE = 2'h0;
	localparam logic [1:0] UNIT_SEC  = 2'h1;
	localparam logic [1:0] UNIT_MIN  = 2'h2;
	localparam logic [1:0] UNIT_HOUR = 2'h3;

	localparam logic [9:0] EXP_DISABLE  = 10'h3ff;
	localparam logic [9:0] EXP_RESET    = 10'h000;
	localparam logic [1:0] UV_EXIT_ALL  = 2'h3;
	localparam logic [7:0] DLY_RESET    = 8'h00;
	localparam logic [7:0] SETTLE_RESET = 8'h00;

	typedef enum logic [2:0] {ST_OFF, ST_CHECK, ST_RUN, ST_DONE, ST_FAULT} cbm_state_t;

	typedef struct packed {
		logic [1:0] balance_state;
		logic [9:0] balance_elapsed_timer;
		logic [1:0] alive_counter;
		logic [1:0] timer_unit_indicator;
	} cbm_status_t;

	typedef struct packed {
		logic aux_over_summary;
		logic aux_under_summary;
	} cbm_status_one_t;

	typedef struct packed {
		logic write_reject_flag;
		logic health_check_fail_flag;
	} cbm_status_two_t;

endpackage

// ### hw/cbm_tick_gen.sv
`timescale 1ns/1ns
module cbm_tick_gen
	import cbm_pkg::*;
#(
	parameter int SEC_CYC = SEC_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic restart,
	output logic      sec_tick,
	output logic      min_tick,
	output logic      hour_tick
);

	localparam int CW = $clog2(SEC_CYC);

	logic [CW-1:0] cyc_cnt;
	logic [5:0]    sec_cnt;
	logic [5:0]    min_cnt;

	if (SEC_CYC < 2) begin : g_chk
		$error("cbm_tick_gen: SEC_CYC must be at least 2");
	end

	// Restart realigns the base so the first unit after a launch is whole
	always_ff @(posedge core_clk) begin
		if (!rst_b || restart) begin
			cyc_cnt  <= '0;
			sec_cnt  <= '0;
			min_cnt  <= '0;
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
			hour_tick <= 1'b0;
		end else begin
			sec_tick  <= 1'b0;
			min_tick  <= 1'b0;
			hour_tick <= 1'b0;
			if (cyc_cnt == CW'(SEC_CYC - 1)) begin
				cyc_cnt  <= '0;
				sec_tick <= 1'b1;
				if (sec_cnt == 6'(UNITS_PER_NEXT - 1)) begin
					sec_cnt  <= '0;
					min_tick <= 1'b1;
					if (min_cnt == 6'(UNITS_PER_NEXT - 1)) begin
						min_cnt   <= '0;
						hour_tick <= 1'b1;
					end else begin
						min_cnt <= min_cnt + 6'h01;
					end
				end else begin
					sec_cnt <= sec_cnt + 6'h01;
				end
			end else begin
				cyc_cnt <= cyc_cnt + CW'(1);
			end
		end
	end

endmodule

// ### tb/cbm_balance_ctrl_tb_top.sv
`timescale 1ns/1ns
module cbm_balance_ctrl_tb_top
	import cbm_pkg::*;
;
	logic                  core_clk = '0, rst_b = '0, mode_wr = '0, swctrl_wr = '0, restart_wdata = '0;
	logic                  exp_wr = '0, uvthr_wr = '0, min_cell_wdata = '0, dlyctrl_wr = '0, settle_wr = '0;
	logic                  measure_suspend_switches = '0, alternate_mux_select = '0, meas_in_progress = '0;
	logic                  scan_in_progress = '0, acq_enable = '0, thermal_fault = '0, hw_check_fail = '0;
	logic                  adc_aux_ov = '0, comp_aux_ov = '0, adc_aux_uv = '0, comp_aux_uv = '0;
	logic                  reject_clr = '0, health_clr = '0, even_phase, odd_phase, settle_done;
	logic [2:0]            mode_wdata = '0, balance_mode_select;
	logic [13:0]           mask_wdata = '0, uvthr_wdata = '0, balance_switch;
	logic [3:0]            exp_idx = '0;
	logic [9:0]            exp_wdata = '0;
	logic [7:0]            dlyctrl_wdata = '0, delay_control;
	logic [15:0]           settle_wdata = '0;
	logic [1:0]            measure_exit_enable = '0;
	logic [13:0][13:0]     cell_voltage = '0;
	cbm_status_t           status;
	cbm_status_one_t       status_word_one;
	cbm_status_two_t       status_word_two;
	int                    num_errors = 0, checks = 0;

	// Short second so a timeout run stays within a few hundred cycles
	cbm_balance_ctrl #(.SEC_CYC(20)) u_cbm_balance_ctrl (.*);

	always #20 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic set_mode(logic [2:0] m);
		mode_wdata = m;
		mode_wr = 1'h1;
		cyc(1);
		mode_wr = 1'h0;
	endtask

	task automatic set_exp(logic [9:0] v);
		exp_idx = 4'h1;
		exp_wdata = v;
		exp_wr = 1'h1;
		cyc(1);
		exp_wr = 1'h0;
	endtask

	task automatic set_sw(logic r, logic [13:0] m);
		restart_wdata = r;
		mask_wdata = m;
		swctrl_wr = 1'h1;
		cyc(1);
		swctrl_wr = 1'h0;
	endtask

	task automatic set_dly(logic [7:0] v);
		dlyctrl_wdata = v;
		dlyctrl_wr = 1'h1;
		cyc(1);
		dlyctrl_wr = 1'h0;
	endtask

	task automatic clr_rej();
		reject_clr = 1'h1;
		cyc(1);
		reject_clr = 1'h0;
	endtask

	// Bounded wait; running out ends the run as a failure
	task automatic wait_state(logic [1:0] e, int lim);
		int i;
		for (i = 0; i < lim && status.balance_state !== e; i++)
			cyc(1);
		if (i == lim) begin
			num_errors++;
			close_out();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_manual();
		set_exp(10'h002);
		set_sw(1'h0, 14'h2a5a);
		set_mode(MODE_MAN_SEC);
		cyc(3);
		chk("sw", 16'h2a5a, balance_switch);
		chk("unit", UNIT_SEC, status.timer_unit_indicator);
		set_exp(10'h3fe);
		chk("rej", 1'h1, status_word_two.write_reject_flag);
		clr_rej();
		measure_suspend_switches = 1'h1;
		meas_in_progress = 1'h1;
		cyc(2);
		chk("susp", 16'h0, balance_switch);
		measure_suspend_switches = 1'h0;
		meas_in_progress = 1'h0;
		wait_state(BST_DONE, 200);
		cyc(1);
		chk("tmr", 16'h3, status.balance_elapsed_timer);
		chk("off", 16'h0, balance_switch);
		chk("mode", MODE_MAN_SEC, balance_mode_select);
		chk("alive", 16'h3, status.alive_counter);
		set_sw(1'h1, 14'h2a5a);
		cyc(2);
		chk("rst", BST_DONE, status.balance_state);
		chk("rtmr", 16'h3, status.balance_elapsed_timer);
		set_mode(MODE_MAN_SEC);
		chk("relaunch", 16'h0, status.balance_elapsed_timer);
		chk("kalive", 16'h3, status.alive_counter);
	endtask

	task automatic t_other();
		set_dly(8'h5a);
		set_mode(MODE_AI_SEC);
		set_sw(1'h0, 14'h0001);
		chk("rej", 1'h1, status_word_two.write_reject_flag);
		cyc(1);
		// Phase 0 drives the even cells 2, 4, .. and raises the even flag
		chk("aisw", 16'h2a0a, balance_switch);
		chk("ph", 16'h2, {even_phase, odd_phase});
		clr_rej();
		wait_state(BST_DONE, 100);
		chk("aioff", 16'h0, balance_switch);
		set_mode(MODE_OFF);
		chk("idle", BST_IDLE, status.balance_state);
		chk("unit", UNIT_NONE, status.timer_unit_indicator);
		cyc(1);
		set_mode(MODE_EMERG);
		set_dly(8'h33);
		chk("dly", 16'h5a, delay_control);
		chk("erej", 1'h1, status_word_two.write_reject_flag);
		chk("hunit", UNIT_HOUR, status.timer_unit_indicator);
		cyc(1);
		// Emergency ignores the mask
		chk("esw", 16'h2aaa, balance_switch);
		thermal_fault = 1'h1;
		cyc(2);
		chk("therm", BST_FAULT, status.balance_state);
		chk("toff", 16'h0, balance_switch);
		thermal_fault = 1'h0;
		set_mode(MODE_OFF);
		hw_check_fail = 1'h1;
		cyc(1);
		set_mode(MODE_MAN_MIN);
		cyc(2);
		hw_check_fail = 1'h0;
		chk("hc", 1'h1, status_word_two.health_check_fail_flag);
		chk("hst", BST_FAULT, status.balance_state);
		comp_aux_ov = 1'h1;
		adc_aux_uv = 1'h1;
		cyc(2);
		chk("sum", 16'h3, status_word_one);
	endtask

	task automatic t_settle();
		int i;
		clr_rej();
		meas_in_progress = 1'h1;
		settle_wdata = 16'hffff;
		settle_wr = 1'h1;
		cyc(1);
		chk("srej", 1'h1, status_word_two.write_reject_flag);
		meas_in_progress = 1'h0;
		// Ten 96 us steps, the cell settling a host picks for a typical filter
		settle_wdata = 16'h0a01;
		cyc(1);
		settle_wr = 1'h0;
		for (int k = 0; k < 2; k++) begin
			measure_suspend_switches = k[0];
			alternate_mux_select = k[0];
			acq_enable = 1'h1;
			cyc(1);
			acq_enable = 1'h0;
			for (i = 0; i < 30000 && settle_done !== 1'h1; i++)
				cyc(1);
			// 2400 clocks per step at 40 ns, plus the registered done pulse
			chk("settle", k ? 16'h0961 : 16'h5dc1, 16'(i));
		end
		measure_suspend_switches = 1'h0;
		alternate_mux_select = 1'h0;
	endtask

	initial begin
		cyc(5);
		rst_b = 1'h1;
		chk("rst", BST_IDLE, status.balance_state);
		t_manual();
		t_other();
		t_settle();
		close_out();
	end
endmodule
